// ==== design/dats_pkg.sv ====
// Constants and types shared by the director ALU test sequencer
package dats_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FILE_ADDR_W = 4;
  localparam int unsigned FILE_DEPTH = 16;
  localparam int unsigned STAGES = 8;
  // Director word fields, bit n of the port is documented bit n
  localparam int unsigned ADDR_LSB = 28;
  localparam int unsigned ADDR_MSB = 31;
  localparam int unsigned OPND_LSB = 8;
  localparam int unsigned OPND_MSB = 23;
  localparam int unsigned TEST_LSB = 24;
  localparam int unsigned TEST_MSB = 26;
  // Positions inside the captured test condition
  localparam int unsigned COND_MAG = 0;
  localparam int unsigned COND_BIT = 1;
  localparam int unsigned COND_DEC = 2;
  // Register port
  localparam int unsigned REG_A_W = 2;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_CATCH = 2'h2;
  localparam logic [3:0] PERIOD_RST = 4'h4;
  localparam logic [3:0] PERIOD_MIN = 4'h2;
  localparam int unsigned ST_EQUAL = 0;
  localparam int unsigned ST_POSITIVE = 1;
  localparam int unsigned ST_NEGATIVE = 2;
  localparam int unsigned ST_BITCMP = 3;
  localparam int unsigned ST_BUSY = 4;
  localparam int unsigned ST_DECR = 5;
  localparam int unsigned ST_NOSTORE = 6;
  localparam int unsigned ST_LOAD = 7;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;

  typedef enum logic [2:0] {
    ALU_PASS = 3'b000,
    ALU_SUB = 3'b001,
    ALU_DEC = 3'b010,
    ALU_COMP = 3'b011,
    ALU_BIT = 3'b100
  } dats_alu_mode_t;

  typedef enum logic [2:0] {
    LD_IDLE = 3'b000,
    LD_ARMED = 3'b001,
    LD_DRIVE = 3'b010,
    LD_HOLD = 3'b011,
    LD_DONE = 3'b100
  } dats_load_state_t;
endpackage

// ==== design/dats_alu.sv ====
// Sixteen-bit ALU with zero, upper carry and bit-match outputs
`timescale 1ns/100ps
module dats_alu (
  input wire logic [dats_pkg::WORD_W-1:0] opA,
  input wire logic [dats_pkg::WORD_W-1:0] opB,
  input wire dats_pkg::dats_alu_mode_t mode,
  output logic [dats_pkg::WORD_W-1:0] result,
  output logic equal,
  output logic upperCarry,
  output logic matchLower,
  output logic matchUpper
);
  import dats_pkg::*;
  logic [WORD_W:0] diff;

  // Subtract without carry in is taken as plain A minus B; the borrow is the sign
  assign diff = {1'b0, opA} - {1'b0, opB};
  assign equal = (diff[WORD_W-1:0] == WORD_ZERO);
  assign upperCarry = diff[WORD_W];
  assign matchLower = |(opA[7:0] & opB[7:0]);
  assign matchUpper = |(opA[15:8] & opB[15:8]);

  always_comb begin
    case (mode)
      ALU_SUB: result = diff[WORD_W-1:0];
      ALU_DEC: result = opA - WORD_ONE;
      ALU_COMP: result = ~opA;
      ALU_BIT: result = opA;
      ALU_PASS: result = opA;
      default: result = opA;
    endcase
  end
endmodule // dats_alu

// ==== design/dats_regfile.sv ====
// Sixteen by sixteen register file, read by default, split byte writes
`timescale 1ns/100ps
module dats_regfile (
  input wire logic clk,
  input wire logic [dats_pkg::FILE_ADDR_W-1:0] addr,
  input wire logic [dats_pkg::WORD_W-1:0] wrData,
  input wire logic writeLower,
  input wire logic writeUpper,
  output logic [dats_pkg::WORD_W-1:0] rdData
);
  import dats_pkg::*;
  logic [WORD_W-1:0] mem [FILE_DEPTH];

  assign rdData = mem[addr];

  always_ff @(posedge clk) begin
    if (writeLower) begin
      mem[addr][7:0] <= wrData[7:0];
    end
    if (writeUpper) begin
      mem[addr][15:8] <= wrData[15:8];
    end
  end
endmodule // dats_regfile

// ==== design/dats_sequencer.sv ====
// Director execution for test, complement and load-file over a timed ALU chain
//
// What this block does
// - Test bit 24: subtract operand from addressed word, set exactly one of equal/positive/negative.
// - Plain magnitude test leaves the addressed word unchanged; result only reaches flags and the catching register.
// - Test bit 26: magnitude test, and if unequal write the word back minus one.
// - Test bit 25: bitwise compare; any matching position sets the bit-compare flag.
// - Execute strobe with load-file address select loads address bits 28-31; the addressed word is operand A.
// - Execute strobe of test or load-file director captures bits 08-23 as operand B.
// - Execute strobe of test captures bits 24-26; they select which flags may set.
// - Every test director clears all four flags before any result is captured.
// - An eight-stage timing chain, one stage per phase a pulse, sequences ALU directors.
// - Magnitude test sets the ALU to subtract without carry at the first step.
// - Equal on zero difference, negative from upper carry, otherwise positive.
// - Bit compare passes the word through the ALU giving lower and upper match.
// - Third step clocks the three sign flags in subtract mode and the bit-compare flag under bit 25; each sets on its condition.
// - Third step sets decrement state when unequal in test-and-decrement mode.
// - Fifth step captures the ALU output in the catching register.
// - Fifth step of a test sets no-store unless decrementing; no-store suppresses writes.
// - Sixth step drives catch onto file bus, drops read drive, clears operation flop.
// - Seventh step asserts lower and upper write enables and raises ALU done.
// - ALU done sets director done, which clears decrement and no-store and holds off the next director until it and its companion clear.
// - Eighth step ends the chain and preclears director done; companion clears next pulse.
// - Complement inverts the addressed word and writes it back through the same chain.
// - Load code 80 sets load state, blocks next request, drives operand on phase b.
// - After the load write, request next director, clear load states, return to read.
`timescale 1ns/100ps
module dats_sequencer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] directorWord,
  input wire logic executeStrobe,
  input wire logic testDecode,
  input wire logic complementDecode,
  input wire logic loadFileDecode,
  input wire logic loadFileAddressSelect,
  input wire logic [dats_pkg::REG_A_W-1:0] regAddr,
  input wire logic [dats_pkg::WORD_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [dats_pkg::WORD_W-1:0] regRdData,
  output logic busy,
  output logic directorDone,
  output logic aluDone,
  output logic nextRequest,
  output logic requestInhibit,
  output logic fileReadDrive,
  output logic catchToFileBus,
  output logic operandToFileBus,
  output logic fileWriteLower,
  output logic fileWriteUpper,
  output logic flagEqual,
  output logic flagPositive,
  output logic flagNegative,
  output logic flagBitCompare
);
  import dats_pkg::*;

  logic [3:0] periodR;
  logic [3:0] divR;
  logic phaseA;
  logic phaseB;
  logic [FILE_ADDR_W-1:0] fileAddrR;
  logic [WORD_W-1:0] operandR;
  logic [2:0] condR;
  logic testOpR;
  logic compOpR;
  logic subModeR;
  logic decR;
  logic noStoreR;
  logic [WORD_W-1:0] catchR;
  logic [STAGES-1:1] chainR;
  logic [STAGES:1] stageFire;
  logic chainStart;
  logic clearCompanionR;
  dats_load_state_t loadStateR;
  dats_load_state_t loadStateNxt;
  dats_alu_mode_t aluMode;
  logic [WORD_W-1:0] fileRdData;
  logic [WORD_W-1:0] fileWrData;
  logic [WORD_W-1:0] aluResult;
  logic aluEqual;
  logic aluUpperCarry;
  logic matchLower;
  logic matchUpper;
  logic busyNow;
  logic accept;
  logic acceptTest;
  logic acceptComp;
  logic acceptLoad;
  logic loadWrite;
  logic loadRelease;
  logic doneSet;
  logic doneClear;
  logic [WORD_W-1:0] statusWord;

  // Internal clock pulses: phase a opens a period, phase b sits half way
  assign phaseA = (divR == 4'h0);
  assign phaseB = (divR == {1'b0, periodR[3:1]});

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divR <= 4'h0;
    end else if (divR >= periodR - 4'h1) begin
      divR <= 4'h0;
    end else begin
      divR <= divR + 4'h1;
    end
  end

  // A new director is taken only when everything from the last one has settled
  assign busyNow = testOpR | compOpR | (|chainR) | directorDone | clearCompanionR
                   | (loadStateR != LD_IDLE);
  assign accept = executeStrobe & ~busyNow;
  assign acceptTest = accept & testDecode;
  assign acceptComp = accept & complementDecode & ~testDecode;
  assign acceptLoad = accept & loadFileDecode & ~testDecode & ~complementDecode;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fileAddrR <= 4'h0;
    end else if (accept & loadFileAddressSelect) begin
      fileAddrR <= directorWord[ADDR_MSB:ADDR_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      operandR <= WORD_ZERO;
    end else if (acceptTest | acceptLoad) begin
      operandR <= directorWord[OPND_MSB:OPND_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      condR <= 3'h0;
    end else if (acceptTest) begin
      condR <= directorWord[TEST_MSB:TEST_LSB];
    end
  end

  // Operation flops; the chain keeps running after they drop at the sixth step
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      testOpR <= 1'b0;
      compOpR <= 1'b0;
    end else begin
      if (acceptTest) begin
        testOpR <= 1'b1;
      end else if (stageFire[6]) begin
        testOpR <= 1'b0;
      end
      if (acceptComp) begin
        compOpR <= 1'b1;
      end else if (stageFire[6]) begin
        compOpR <= 1'b0;
      end
    end
  end

  // Timing chain: stage n fires on the pulse after stage n-1; stage 8 only clears
  assign chainStart = (testOpR | compOpR) & ~(|chainR) & ~directorDone;
  assign stageFire[1] = phaseA & chainStart;
  genvar n;
  generate
    for (n = 2; n <= STAGES; n++) begin : g_stage
      assign stageFire[n] = phaseA & chainR[n-1];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chainR <= '0;
    end else if (phaseA) begin
      chainR <= stageFire[STAGES-1:1];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      subModeR <= 1'b0;
    end else if (stageFire[1] & testOpR & (condR[COND_MAG] | condR[COND_DEC])) begin
      subModeR <= 1'b1;
    end else if (doneClear) begin
      subModeR <= 1'b0;
    end
  end

  // Mode priority: complement, bit compare, decrement, subtract, pass
  always_comb begin
    if (compOpR) begin
      aluMode = ALU_COMP;
    end else if (testOpR & condR[COND_BIT]) begin
      aluMode = ALU_BIT;
    end else if (decR) begin
      aluMode = ALU_DEC;
    end else if (subModeR) begin
      aluMode = ALU_SUB;
    end else begin
      aluMode = ALU_PASS;
    end
  end

  // Flags stay put until the next test director is accepted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flagEqual <= 1'b0;
      flagPositive <= 1'b0;
      flagNegative <= 1'b0;
      flagBitCompare <= 1'b0;
    end else if (acceptTest) begin
      flagEqual <= 1'b0;
      flagPositive <= 1'b0;
      flagNegative <= 1'b0;
      flagBitCompare <= 1'b0;
    end else if (stageFire[3] & testOpR) begin
      if (subModeR) begin
        flagEqual <= aluEqual;
        flagNegative <= ~aluEqual & aluUpperCarry;
        flagPositive <= ~aluEqual & ~aluUpperCarry;
      end
      if (condR[COND_BIT]) begin
        flagBitCompare <= matchLower | matchUpper;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      decR <= 1'b0;
    end else if (stageFire[3] & testOpR & condR[COND_DEC] & ~aluEqual) begin
      decR <= 1'b1;
    end else if (directorDone) begin
      decR <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      catchR <= WORD_ZERO;
    end else if (stageFire[5]) begin
      catchR <= aluResult;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      noStoreR <= 1'b0;
    end else if (stageFire[5] & testOpR & ~decR) begin
      noStoreR <= 1'b1;
    end else if (directorDone) begin
      noStoreR <= 1'b0;
    end
  end

  // Load-file sequence, paced by the two internal phases
  always_comb begin
    loadStateNxt = loadStateR;
    case (loadStateR)
      LD_IDLE: begin
        if (acceptLoad) begin
          loadStateNxt = LD_ARMED;
        end
      end
      LD_ARMED: begin
        if (phaseB) begin
          loadStateNxt = LD_DRIVE;
        end
      end
      LD_DRIVE: begin
        if (phaseB) begin
          loadStateNxt = LD_HOLD;
        end
      end
      LD_HOLD: begin
        if (phaseA) begin
          loadStateNxt = LD_DONE;
        end
      end
      LD_DONE: begin
        if (phaseA) begin
          loadStateNxt = LD_IDLE;
        end
      end
      default: loadStateNxt = LD_IDLE;
    endcase
  end

  assign loadWrite = (loadStateR == LD_DRIVE) & phaseB;
  assign loadRelease = (loadStateR == LD_HOLD) & phaseA;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loadStateR <= LD_IDLE;
    end else begin
      loadStateR <= loadStateNxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      requestInhibit <= 1'b0;
      nextRequest <= 1'b0;
    end else begin
      if (acceptLoad) begin
        requestInhibit <= 1'b1;
      end else if (loadWrite) begin
        requestInhibit <= 1'b0;
      end
      nextRequest <= loadWrite;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      operandToFileBus <= 1'b0;
    end else if ((loadStateR == LD_ARMED) & phaseB) begin
      operandToFileBus <= 1'b1;
    end else if (loadRelease) begin
      operandToFileBus <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      catchToFileBus <= 1'b0;
    end else if (stageFire[6]) begin
      catchToFileBus <= 1'b1;
    end else if (stageFire[8]) begin
      catchToFileBus <= 1'b0;
    end
  end

  // Read drive falls whenever something else owns the file bus
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fileReadDrive <= 1'b1;
    end else if (stageFire[6] | ((loadStateR == LD_ARMED) & phaseB)) begin
      fileReadDrive <= 1'b0;
    end else if (stageFire[8] | loadRelease) begin
      fileReadDrive <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fileWriteLower <= 1'b0;
      fileWriteUpper <= 1'b0;
      aluDone <= 1'b0;
    end else begin
      fileWriteLower <= (stageFire[7] & ~noStoreR) | loadWrite;
      fileWriteUpper <= (stageFire[7] & ~noStoreR) | loadWrite;
      aluDone <= stageFire[7];
    end
  end

  // Director done: set by ALU done or load release, preclear at step 8 or next phase a
  assign doneSet = aluDone | loadRelease;
  assign doneClear = stageFire[8] | ((loadStateR == LD_DONE) & phaseA);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      directorDone <= 1'b0;
    end else if (doneSet) begin
      directorDone <= 1'b1;
    end else if (doneClear) begin
      directorDone <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clearCompanionR <= 1'b0;
    end else if (doneSet) begin
      clearCompanionR <= 1'b1;
    end else if (phaseA & ~directorDone) begin
      clearCompanionR <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      busy <= busyNow;
    end
  end

  assign fileWrData = catchToFileBus ? catchR : operandR;

  dats_regfile u_regfile (
    .clk(clk),
    .addr(fileAddrR),
    .wrData(fileWrData),
    .writeLower(fileWriteLower),
    .writeUpper(fileWriteUpper),
    .rdData(fileRdData)
  );

  dats_alu u_alu (
    .opA(fileRdData),
    .opB(operandR),
    .mode(aluMode),
    .result(aluResult),
    .equal(aluEqual),
    .upperCarry(aluUpperCarry),
    .matchLower(matchLower),
    .matchUpper(matchUpper)
  );

  // Register port: period control, status and the last caught ALU result
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      periodR <= PERIOD_RST;
    end else if (regWrite && (regAddr == REG_CTRL)) begin
      // Too short a period would merge the two phases
      periodR <= (regWrData[3:0] < PERIOD_MIN) ? PERIOD_MIN : regWrData[3:0];
    end
  end

  always_comb begin
    statusWord = WORD_ZERO;
    statusWord[ST_EQUAL] = flagEqual;
    statusWord[ST_POSITIVE] = flagPositive;
    statusWord[ST_NEGATIVE] = flagNegative;
    statusWord[ST_BITCMP] = flagBitCompare;
    statusWord[ST_BUSY] = busyNow;
    statusWord[ST_DECR] = decR;
    statusWord[ST_NOSTORE] = noStoreR;
    statusWord[ST_LOAD] = (loadStateR != LD_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= WORD_ZERO;
    end else if (regRead) begin
      case (regAddr)
        REG_CTRL: regRdData <= {12'h000, periodR};
        REG_STATUS: regRdData <= statusWord;
        REG_CATCH: regRdData <= catchR;
        default: regRdData <= WORD_ZERO;
      endcase
    end else begin
      regRdData <= WORD_ZERO;
    end
  end
endmodule // dats_sequencer

// ==== tb/dats_director_model.sv ====
// Behavioural director fetch and decode stage feeding the sequencer
`timescale 1ns/100ps
module dats_director_model (
  input wire logic clk,
  input wire logic busy,
  input wire logic requestInhibit,
  output logic [31:0] directorWord,
  output logic executeStrobe,
  output logic testDecode,
  output logic complementDecode,
  output logic loadFileDecode,
  output logic loadFileAddressSelect
);
  initial begin
    directorWord = 32'h0000_0000;
    executeStrobe = 1'h0;
    {testDecode, complementDecode, loadFileDecode, loadFileAddressSelect} = 4'h0;
  end

  // Kind 0 test, 1 complement, 2 load; gap idles the fetch to model a slow read chain
  task automatic issue(input logic [1:0] kind, input logic [3:0] addr, input logic [15:0] opnd,
                       input logic [2:0] cond, input int gap);
    int n;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    directorWord <= {addr, 1'h0, cond, opnd, 8'h00};
    testDecode <= (kind == 2'h0);
    complementDecode <= (kind == 2'h1);
    loadFileDecode <= (kind == 2'h2);
    loadFileAddressSelect <= 1'h1;
    executeStrobe <= 1'h1;
    @(posedge clk);
    executeStrobe <= 1'h0;
    // Word is scrambled once taken so a late capture cannot pass by luck
    directorWord <= ~{addr, 1'h0, cond, opnd, 8'h00};
    {testDecode, complementDecode, loadFileDecode, loadFileAddressSelect} <= 4'h0;
    n = 0;
    do @(posedge clk); while (busy !== 1'h1 && ++n < 8);
    n = 0;
    do @(posedge clk); while ((busy | requestInhibit) !== 1'h0 && ++n < 600);
  endtask
endmodule // dats_director_model

// ==== tb/dats_sequencer_properties.sv ====
// Port-level properties of the director sequencer
`timescale 1ns/100ps
module dats_sequencer_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic executeStrobe,
  input wire logic busy,
  input wire logic directorDone,
  input wire logic aluDone,
  input wire logic nextRequest,
  input wire logic requestInhibit,
  input wire logic fileReadDrive,
  input wire logic catchToFileBus,
  input wire logic operandToFileBus,
  input wire logic fileWriteLower,
  input wire logic fileWriteUpper,
  input wire logic flagEqual,
  input wire logic flagPositive,
  input wire logic flagNegative,
  input wire logic flagBitCompare
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_doneFollows;
    aluDone ##1 directorDone;
  endsequence
  property p_write_pair;
    fileWriteLower || fileWriteUpper |-> fileWriteLower && fileWriteUpper && (aluDone || nextRequest);
  endproperty
  a_write_pair: assert property (p_write_pair) else $error("split or stray file write");
  property p_write_src;
    fileWriteLower |-> !fileReadDrive && (catchToFileBus || operandToFileBus);
  endproperty
  a_write_src: assert property (p_write_src) else $error("file write without bus source");
  property p_done_seq;
    aluDone |-> s_doneFollows;
  endproperty
  a_done_seq: assert property (p_done_seq) else $error("director done did not follow");
  property p_done_bus;
    aluDone |-> catchToFileBus && !fileReadDrive;
  endproperty
  a_done_bus: assert property (p_done_bus) else $error("catch not on bus at done");
  property p_step7;
    $rose(catchToFileBus) |-> ##[1:40] aluDone;
  endproperty
  a_step7: assert property (p_step7) else $error("no done after bus drive");
  property p_step8;
    $fell(catchToFileBus) |-> fileReadDrive && !directorDone;
  endproperty
  a_step8: assert property (p_step8) else $error("chain end left file or done wrong");
  property p_one_sign;
    $onehot0({flagEqual, flagPositive, flagNegative});
  endproperty
  a_one_sign: assert property (p_one_sign) else $error("more than one sign flag");
  property p_flags_hold;
    !$stable({flagEqual, flagPositive, flagNegative, flagBitCompare}) |->
      $past(busy) || $past(executeStrobe);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags moved while idle");
  property p_load_drive;
    $rose(operandToFileBus) |-> requestInhibit && !fileReadDrive;
  endproperty
  a_load_drive: assert property (p_load_drive) else $error("operand drive without inhibit");
  property p_next_req;
    nextRequest |-> fileWriteLower && operandToFileBus;
  endproperty
  a_next_req: assert property (p_next_req) else $error("next request without load write");
endmodule // dats_sequencer_properties

bind dats_sequencer dats_sequencer_properties chk (
  .clk(clk), .rst_b(rst_b), .executeStrobe(executeStrobe), .busy(busy),
  .directorDone(directorDone), .aluDone(aluDone), .nextRequest(nextRequest),
  .requestInhibit(requestInhibit), .fileReadDrive(fileReadDrive),
  .catchToFileBus(catchToFileBus), .operandToFileBus(operandToFileBus),
  .fileWriteLower(fileWriteLower), .fileWriteUpper(fileWriteUpper), .flagEqual(flagEqual),
  .flagPositive(flagPositive), .flagNegative(flagNegative), .flagBitCompare(flagBitCompare)
);

// ==== tb/test_dats_sequencer.sv ====
// Self-checking bench for the director sequencer
`timescale 1ns/100ps
module test_dats_sequencer;
  import dats_pkg::*;
  logic clk, rst_b, regWrite, regRead, busy, directorDone, aluDone, nextRequest, requestInhibit;
  logic executeStrobe, testDecode, complementDecode, loadFileDecode, loadFileAddressSelect;
  logic fileReadDrive, catchToFileBus, operandToFileBus, fileWriteLower, fileWriteUpper;
  logic flagEqual, flagPositive, flagNegative, flagBitCompare;
  logic [31:0] directorWord;
  logic [REG_A_W-1:0] regAddr;
  logic [WORD_W-1:0] regWrData, regRdData, rd;
  int failCount, nTests;

  dats_sequencer uut (.clk(clk), .rst_b(rst_b), .directorWord(directorWord),
    .executeStrobe(executeStrobe), .testDecode(testDecode), .complementDecode(complementDecode),
    .loadFileDecode(loadFileDecode), .loadFileAddressSelect(loadFileAddressSelect),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .busy(busy), .directorDone(directorDone), .aluDone(aluDone),
    .nextRequest(nextRequest), .requestInhibit(requestInhibit), .fileReadDrive(fileReadDrive),
    .catchToFileBus(catchToFileBus), .operandToFileBus(operandToFileBus),
    .fileWriteLower(fileWriteLower), .fileWriteUpper(fileWriteUpper), .flagEqual(flagEqual),
    .flagPositive(flagPositive), .flagNegative(flagNegative), .flagBitCompare(flagBitCompare));

  dats_director_model fetch (.clk(clk), .busy(busy), .requestInhibit(requestInhibit),
    .directorWord(directorWord), .executeStrobe(executeStrobe), .testDecode(testDecode),
    .complementDecode(complementDecode), .loadFileDecode(loadFileDecode),
    .loadFileAddressSelect(loadFileAddressSelect));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic printVerdict;
    if (failCount == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic checkFlags(input logic [3:0] exp);
    checkWord({12'h000, flagBitCompare, flagNegative, flagPositive, flagEqual}, {12'h000, exp});
  endtask

  task automatic regWr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask

  task automatic regRd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk);
    regRead <= 1'h0;
    @(posedge clk);
    d = regRdData;
  endtask

  // Test director, then flags and, except for a pure bit compare, the caught result
  // A fetch wait that ran out leaves busy high and counts as a mismatch here
  task automatic tst(input logic [3:0] a, input logic [15:0] op, input logic [2:0] cond,
                     input logic [3:0] fl, input logic [15:0] c);
    fetch.issue(2'h0, a, op, cond, 0);
    checkWord({15'h0000, busy}, 16'h0000);
    checkFlags(fl);
    if (cond != 3'h2) begin
      regRd(REG_CATCH, rd);
      checkWord(rd, c);
    end
  endtask

  // Runs at the reset pulse period, the rest at the minimum
  task automatic scMagnitude;
    fetch.issue(2'h2, 4'h5, 16'h1234, 3'h0, 3);
    tst(4'h5, 16'h1234, 3'h1, 4'h1, 16'h0000);
    tst(4'h5, 16'h1200, 3'h1, 4'h2, 16'h0034);
    tst(4'h5, 16'h1300, 3'h1, 4'h4, 16'hFF34);
    tst(4'h5, 16'h1234, 3'h1, 4'h1, 16'h0000);
  endtask

  task automatic scRegisters;
    regRd(REG_CTRL, rd);
    checkWord(rd, {12'h000, PERIOD_RST});
    @(posedge clk);
    checkWord(regRdData, 16'h0000);
    regWr(2'h3, 16'hFFFF);
    regRd(2'h3, rd);
    checkWord(rd, 16'h0000);
    regWr(REG_STATUS, 16'hFFFF);
    regRd(REG_STATUS, rd);
    checkWord(rd, 16'h0001);
    regWr(REG_CTRL, 16'h0000);
    regRd(REG_CTRL, rd);
    checkWord(rd, {12'h000, PERIOD_MIN});
  endtask

  task automatic scDecrement;
    fetch.issue(2'h2, 4'hF, 16'h0000, 3'h0, 0);
    tst(4'hF, 16'h0001, 3'h4, 4'h4, 16'hFFFF);
    tst(4'hF, 16'hFFFF, 3'h4, 4'h1, 16'h0000);
    fetch.issue(2'h2, 4'h0, 16'h5A5A, 3'h0, 1);
    tst(4'hF, 16'hFFFF, 3'h1, 4'h1, 16'h0000);
  endtask

  task automatic scBitCompare;
    tst(4'h5, 16'h0004, 3'h2, 4'h8, 16'h0000);
    tst(4'h5, 16'h1000, 3'h2, 4'h8, 16'h0000);
    tst(4'h5, 16'hEDCB, 3'h2, 4'h0, 16'h0000);
    // Bit compare routes the word through unchanged, so the catch holds the word
    tst(4'h5, 16'h1234, 3'h3, 4'h9, 16'h1234);
  endtask

  task automatic scComplement;
    fetch.issue(2'h1, 4'h5, 16'h0000, 3'h0, 5);
    checkFlags(4'h9);
    regRd(REG_CATCH, rd);
    checkWord(rd, 16'hEDCB);
    tst(4'h5, 16'hEDCB, 3'h1, 4'h1, 16'h0000);
  endtask

  initial begin
    rst_b = 1'h0;
    regWrite = 1'h0;
    regRead = 1'h0;
    regAddr = 2'h0;
    regWrData = 16'h0000;
    failCount = 0;
    nTests = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    scMagnitude();
    scRegisters();
    scDecrement();
    scBitCompare();
    scComplement();
    printVerdict();
  end

  // Whole run needs under a thousand cycles even at the slow period
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    printVerdict();
  end
endmodule // test_dats_sequencer
